// ---- core/port_phy_pkg.sv ----
// Shared constants and types for the per-port PHY control register slice.
// Assumes one 20 MHz clock and an APB master with 32-bit data words.
package port_phy_pkg;

  localparam int NUM_PORTS = 3;
  localparam int ADDR_W    = 10;
  localparam int DATA_W    = 32;
  localparam int BYTE_W    = 8;
  localparam int DIST_W    = 9;

  // Printed register indices of port 1; byte address is four times these.
  localparam logic [7:0] CTRL8_IDX  = 8'h1a;
  localparam logic [7:0] RESULT_IDX = 8'h1b;
  localparam logic [7:0] FORCE_IDX  = 8'h1c;
  localparam logic [7:0] MISC_IDX   = 8'h1d;
  localparam logic [3:0] PORT_NIB_FIRST = CTRL8_IDX[7:4];
  localparam logic [3:0] PORT_NIB_CNT   = 4'h3;

  // Register select within one port, as index minus the control 8 index.
  localparam logic [1:0] SEL_CTRL8  = 2'(RESULT_IDX - CTRL8_IDX - 8'h01);
  localparam logic [1:0] SEL_RESULT = 2'(RESULT_IDX - CTRL8_IDX);
  localparam logic [1:0] SEL_FORCE  = 2'(FORCE_IDX - CTRL8_IDX);
  localparam logic [1:0] SEL_MISC   = 2'(MISC_IDX - CTRL8_IDX);

  // Field positions.
  localparam int C8_SHORT      = 7;
  localparam int C8_OUTCOME_LO = 5;
  localparam int C8_LAUNCH     = 4;
  localparam int C8_FORCE_LINK = 3;
  localparam int C8_PWRSAVE    = 2;
  localparam int C8_LOOPBACK   = 1;
  localparam int C8_DIST_MSB   = 0;
  localparam int C9_AN_DIS     = 7;
  localparam int C9_SPEED      = 6;
  localparam int C9_DUPLEX     = 5;
  localparam int C9_RESV_LO    = 0;
  localparam int C10_IND_OFF   = 7;
  localparam int C10_TXDIS     = 6;
  localparam int C10_RESTART   = 5;
  localparam int RESV_W        = 5;

  localparam logic [RESV_W-1:0] FORCE_RESV_VAL = 5'h1f;
  localparam logic [2:0]        IND_OFF_LEVEL  = 3'h7;
  localparam logic [DIST_W-1:0] DIST_RST       = 9'h000;
  // Software scale: decimetres per fault count unit (about 0.4 m).
  localparam int DIST_DM_PER_COUNT = 4;

  typedef enum logic [1:0] {
    OUTCOME_NORMAL = 2'h0,
    OUTCOME_OPEN   = 2'h1,
    OUTCOME_SHORT  = 2'h2,
    OUTCOME_FAILED = 2'h3
  } cable_outcome_t;

  typedef struct packed {
    logic           short10;
    cable_outcome_t outcome;
    logic [DIST_W-1:0] distance;
  } cable_result_t;

  localparam cable_result_t RESULT_RST = '{
    short10: 1'b0, outcome: OUTCOME_NORMAL, distance: DIST_RST};

  typedef struct packed {
    logic          test_done;
    cable_result_t result;
    logic          an_failed;
    logic          an_speed_100;
    logic          an_duplex_full;
  } phy_status_t;

  typedef struct packed {
    logic autoneg_enable;
    logic speed_100;
    logic duplex_full;
    logic autoneg_restart;
    logic cable_test_start;
    logic loopback;
    logic transmit_disable;
  } phy_ctrl_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } line_sym_t;

  localparam line_sym_t LINE_IDLE = '{pos: 1'b0, neg: 1'b0};

  typedef struct packed {
    logic two;
    logic one;
    logic zero;
  } ind_t;

  typedef struct packed {
    logic loopback;
    logic force_link;
    logic pwrsave;
    logic launch;
    logic an_disable;
    logic forced_speed;
    logic forced_duplex;
    logic indicator_off;
    logic transmit_disable;
    logic autoneg_restart;
  } port_regs_t;

  localparam port_regs_t PORT_REGS_RST = '{
    loopback: 1'b0, force_link: 1'b0, pwrsave: 1'b0, launch: 1'b0,
    an_disable: 1'b0, forced_speed: 1'b1, forced_duplex: 1'b0,
    indicator_off: 1'b0, transmit_disable: 1'b0, autoneg_restart: 1'b0};

  typedef struct packed {
    logic       hit;
    logic [1:0] port;
    logic [1:0] sel;
  } dec_t;

  // Reserved slots of absent ports and gaps miss, so they read zero.
  function automatic dec_t decode(input logic [ADDR_W-1:0] a);
    dec_t       d;
    logic [7:0] idx;
    logic [3:0] nib;
    idx    = a[ADDR_W-1:2];
    nib    = idx[7:4] - PORT_NIB_FIRST;
    d.hit  = (a[1:0] == 2'h0) && (idx[7:4] >= PORT_NIB_FIRST) &&
             (nib < PORT_NIB_CNT) && (idx[3:0] >= CTRL8_IDX[3:0]) &&
             (idx[3:0] <= MISC_IDX[3:0]);
    d.port = nib[1:0];
    d.sel  = 2'(idx[3:0] - CTRL8_IDX[3:0]);
    return d;
  endfunction

endpackage

// ---- core/cable_result_capture.sv ----
// Holds one port's cable test result between tests.
// Assumes the PHY pulses test_done for one pclk cycle with the result valid.
module cable_result_capture
  import port_phy_pkg::*;
(
  input  wire logic    pclk,
  input  wire logic    presetn,
  input  wire logic    launch,
  input  phy_status_t  status,
  output cable_result_t result
);

  cable_result_t result_q;
  cable_result_t result_d;

  // A done pulse with no test running is stray and is ignored.
  always_comb begin
    result_d = result_q;
    if (status.test_done && launch) begin
      result_d = status.result;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_q <= RESULT_RST;
    end else begin
      result_q <= result_d;
    end
  end

  assign result = result_q;

endmodule // cable_result_capture

// ---- core/port_line_drive.sv ----
// Registered line-side controls, transmit path and indicators of one port.
// Assumes receive symbols, MAC symbols and raw indicators are on pclk.
module port_line_drive
  import port_phy_pkg::*;
(
  input  wire logic   pclk,
  input  wire logic   presetn,
  input  port_regs_t  regs,
  input  phy_status_t status,
  input  line_sym_t   rx_line,
  input  line_sym_t   mac_tx,
  input  ind_t        ind_raw,
  output phy_ctrl_t   ctrl,
  output line_sym_t   tx_line,
  output ind_t        indicators
);

  phy_ctrl_t ctrl_q;
  phy_ctrl_t ctrl_d;
  line_sym_t tx_q;
  line_sym_t tx_d;
  ind_t      ind_q;
  ind_t      ind_d;
  logic      launch_q;

  always_comb begin
    ctrl_d.autoneg_enable   = !regs.an_disable;
    ctrl_d.speed_100        = regs.an_disable ? regs.forced_speed
                                              : status.an_speed_100;
    ctrl_d.duplex_full      = (regs.an_disable || status.an_failed)
                              ? regs.forced_duplex
                              : status.an_duplex_full;
    ctrl_d.autoneg_restart  = regs.autoneg_restart;
    ctrl_d.cable_test_start = regs.launch && !launch_q;
    ctrl_d.loopback         = regs.loopback;
    ctrl_d.transmit_disable = regs.transmit_disable;
    // A disabled transmitter stays silent even in remote loopback.
    if (regs.transmit_disable) begin
      tx_d = LINE_IDLE;
    end else if (regs.loopback) begin
      tx_d = rx_line;
    end else begin
      tx_d = mac_tx;
    end
    ind_d = regs.indicator_off ? ind_t'(IND_OFF_LEVEL) : ind_raw;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q   <= '0;
      tx_q     <= LINE_IDLE;
      ind_q    <= ind_t'(IND_OFF_LEVEL);
      launch_q <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      tx_q     <= tx_d;
      ind_q    <= ind_d;
      launch_q <= regs.launch;
    end
  end

  assign ctrl       = ctrl_q;
  assign tx_line    = tx_q;
  assign indicators = ind_q;

endmodule // port_line_drive

// ---- core/port_phy_control_regs.sv ----
// APB register slice for the PHY control registers of each switch port.
// Assumes an APB master on pclk; the PHY side runs on pclk as well.
//
// The APB interface to the registers was decided locally.
module port_phy_control_regs
  import port_phy_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0]      prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  phy_status_t            phy_status [NUM_PORTS],
  input  line_sym_t              rx_line    [NUM_PORTS],
  input  line_sym_t              mac_tx     [NUM_PORTS],
  input  ind_t                   ind_raw    [NUM_PORTS],
  output phy_ctrl_t              phy_ctrl   [NUM_PORTS],
  output line_sym_t              tx_line    [NUM_PORTS],
  output ind_t                   indicators [NUM_PORTS]
);

  port_regs_t    regs_q [NUM_PORTS];
  port_regs_t    regs_d [NUM_PORTS];
  cable_result_t result [NUM_PORTS];
  logic [DATA_W-1:0] prdata_q;
  logic [DATA_W-1:0] prdata_d;
  logic              pready_q;
  logic              pready_d;
  logic              pslverr_q;
  logic [BYTE_W-1:0] rd_byte;
  logic [BYTE_W-1:0] wbyte;
  logic              setup;
  logic              wr_take;
  dec_t              dec;

  assign dec     = decode(paddr);
  assign setup   = psel && !penable;
  assign wr_take = psel && penable && pready_q && pwrite && dec.hit;
  assign wbyte   = pwdata[BYTE_W-1:0];

  // Register state of every port; writes act only at the taking edge.
  always_comb begin
    for (int i = 0; i < NUM_PORTS; i++) begin
      regs_d[i] = regs_q[i];
      regs_d[i].autoneg_restart = 1'b0;
      if (phy_status[i].test_done) begin
        regs_d[i].launch = 1'b0;
      end
      // The write comes last so a launch written with done still stands.
      if (wr_take && (dec.port == 2'(i))) begin
        case (dec.sel)
          SEL_CTRL8: begin
            regs_d[i].loopback   = wbyte[C8_LOOPBACK];
            regs_d[i].force_link = wbyte[C8_FORCE_LINK];
            regs_d[i].pwrsave    = wbyte[C8_PWRSAVE];
            regs_d[i].launch     = wbyte[C8_LAUNCH];
          end
          SEL_FORCE: begin
            regs_d[i].an_disable    = wbyte[C9_AN_DIS];
            regs_d[i].forced_speed  = wbyte[C9_SPEED];
            regs_d[i].forced_duplex = wbyte[C9_DUPLEX];
          end
          SEL_MISC: begin
            regs_d[i].indicator_off    = wbyte[C10_IND_OFF];
            regs_d[i].transmit_disable = wbyte[C10_TXDIS];
            regs_d[i].autoneg_restart  = wbyte[C10_RESTART];
          end
          default: begin
            regs_d[i] = regs_d[i];
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        regs_q[i] <= PORT_REGS_RST;
      end
    end else begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        regs_q[i] <= regs_d[i];
      end
    end
  end

  // Read view of the addressed register; unmapped slots read zero.
  always_comb begin
    rd_byte = '0;
    if (dec.hit) begin
      case (dec.sel)
        SEL_CTRL8: begin
          rd_byte[C8_SHORT] = result[dec.port].short10;
          rd_byte[C8_OUTCOME_LO +: 2] = result[dec.port].outcome;
          rd_byte[C8_LAUNCH]     = regs_q[dec.port].launch;
          rd_byte[C8_FORCE_LINK] = regs_q[dec.port].force_link;
          rd_byte[C8_PWRSAVE]    = regs_q[dec.port].pwrsave;
          rd_byte[C8_LOOPBACK]   = regs_q[dec.port].loopback;
          rd_byte[C8_DIST_MSB] =
            result[dec.port].distance[DIST_W-1];
        end
        SEL_RESULT: begin
          rd_byte = result[dec.port].distance[BYTE_W-1:0];
        end
        SEL_FORCE: begin
          rd_byte[C9_AN_DIS] = regs_q[dec.port].an_disable;
          rd_byte[C9_SPEED]  = regs_q[dec.port].forced_speed;
          rd_byte[C9_DUPLEX] = regs_q[dec.port].forced_duplex;
          rd_byte[C9_RESV_LO +: RESV_W] = FORCE_RESV_VAL;
        end
        default: begin
          rd_byte[C10_IND_OFF] = regs_q[dec.port].indicator_off;
          rd_byte[C10_TXDIS]   = regs_q[dec.port].transmit_disable;
          rd_byte[C10_RESTART] = regs_q[dec.port].autoneg_restart;
        end
      endcase
    end
  end

  // No wait state: data are registered in setup so every bus output is
  // a flip-flop, and pready is high in the first access cycle.
  always_comb begin
    pready_d = setup;
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = {{(DATA_W-BYTE_W){1'b0}}, rd_byte};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    cable_result_capture u_capture (
      .pclk    (pclk),
      .presetn (presetn),
      .launch  (regs_q[i].launch),
      .status  (phy_status[i]),
      .result  (result[i])
    );

    port_line_drive u_drive (
      .pclk       (pclk),
      .presetn    (presetn),
      .regs       (regs_q[i]),
      .status     (phy_status[i]),
      .rx_line    (rx_line[i]),
      .mac_tx     (mac_tx[i]),
      .ind_raw    (ind_raw[i]),
      .ctrl       (phy_ctrl[i]),
      .tx_line    (tx_line[i]),
      .indicators (indicators[i])
    );
  end

endmodule // port_phy_control_regs

// ---- tb/port_phy_control_regs_checker.sv ----
// Port 1 assertions for the PHY control register slice.
// Assumes port 1 traffic stands for all three identical ports.
module port_phy_control_regs_checker
  import port_phy_pkg::*;
(
  input wire logic    pclk,
  input wire logic    presetn,
  input wire logic    psel,
  input wire logic    penable,
  input wire logic    pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input logic [DATA_W-1:0] prdata,
  input logic         pready,
  input logic         pslverr,
  input phy_status_t  phy_status [NUM_PORTS],
  input line_sym_t    rx_line [NUM_PORTS],
  input line_sym_t    mac_tx [NUM_PORTS],
  input ind_t         ind_raw [NUM_PORTS],
  input phy_ctrl_t    phy_ctrl [NUM_PORTS],
  input line_sym_t    tx_line [NUM_PORTS],
  input ind_t         indicators [NUM_PORTS]
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable && pready;
  endsequence
  sequence s_rst_wr;
    s_acc ##0 (pwrite && paddr == 10'h074 && pwdata[5]);
  endsequence
  property p_ready; psel && !penable |=> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_clean; pready |-> !pslverr && prdata[31:8] == 24'h0;
  endproperty
  property p_restart;
    s_rst_wr |-> ##[1:3] phy_ctrl[0].autoneg_restart;
  endproperty
  property p_rs_pulse; phy_ctrl[0].autoneg_restart |=>
    !phy_ctrl[0].autoneg_restart; endproperty
  property p_ct_pulse; phy_ctrl[0].cable_test_start |=>
    !phy_ctrl[0].cable_test_start; endproperty
  property p_speed; phy_ctrl[0].autoneg_enable |->
    phy_ctrl[0].speed_100 == $past(phy_status[0].an_speed_100);
  endproperty
  property p_duplex;
    phy_ctrl[0].autoneg_enable && !$past(phy_status[0].an_failed) |->
    phy_ctrl[0].duplex_full == $past(phy_status[0].an_duplex_full);
  endproperty
  property p_ind; indicators[0] != 3'h7 |->
    indicators[0] == $past(ind_raw[0]); endproperty
  property p_tx; tx_line[0] != LINE_IDLE |->
    tx_line[0] == $past(rx_line[0]) || tx_line[0] == $past(mac_tx[0]);
  endproperty
  a_ready: assert property (p_ready) else $error("no ready");
  a_ready_one: assert property (p_ready_one) else $error("long ready");
  a_clean: assert property (p_clean) else $error("bad response");
  a_restart: assert property (p_restart) else $error("no restart");
  a_rs_pulse: assert property (p_rs_pulse) else $error("rs len");
  a_ct_pulse: assert property (p_ct_pulse) else $error("ct len");
  a_speed: assert property (p_speed) else $error("speed");
  a_duplex: assert property (p_duplex) else $error("duplex");
  a_ind: assert property (p_ind) else $error("indicators");
  a_tx: assert property (p_tx) else $error("tx line");
endmodule // port_phy_control_regs_checker

bind port_phy_control_regs port_phy_control_regs_checker chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .phy_status(phy_status),
  .rx_line(rx_line), .mac_tx(mac_tx), .ind_raw(ind_raw),
  .phy_ctrl(phy_ctrl), .tx_line(tx_line), .indicators(indicators));

// ---- tb/tb_port_phy_control_regs.sv ----
// Self-checking APB bench for the PHY control register slice.
// Assumes the slice answers each access by itself within a few cycles.
module tb_port_phy_control_regs import port_phy_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic [DATA_W-1:0] rd;
  logic              pready;
  logic              pslverr;
  logic [8:0]        dv;
  logic [8:0]        dvr;
  logic [7:0]        prev8;
  phy_status_t       st [NUM_PORTS];
  line_sym_t         rx [NUM_PORTS];
  line_sym_t         mtx [NUM_PORTS];
  ind_t              iraw [NUM_PORTS];
  phy_ctrl_t         ctl [NUM_PORTS];
  line_sym_t         txl [NUM_PORTS];
  ind_t              ind [NUM_PORTS];
  int fail_count = 0;
  int checks = 0;
  int n_rst = 0;
  int n_cts = 0;

  port_phy_control_regs dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_status(st), .rx_line(rx), .mac_tx(mtx),
    .ind_raw(iraw), .phy_ctrl(ctl), .tx_line(txl), .indicators(ind));

  initial forever #25 pclk = ~pclk;

  always @(posedge pclk) begin
    if (ctl[0].autoneg_restart === 1'b1) n_rst++;
    if (ctl[0].cable_test_start === 1'b1) n_cts++;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rdc(input string nm, input logic [9:0] a,
                     input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(nm, {24'h0, e}, rd);
  endtask

  // Reserved low bits must read ones whatever was written.
  task automatic fc(input logic [7:0] fw, input logic f,
                    input logic [6:0] e);
    st[0].an_failed <= f;
    apb(1'b1, 10'h070, fw);
    rdc("force", 10'h070, fw | 8'h1f);
    repeat (2) @(posedge pclk);
    chk("ctl", 32'(e), 32'(ctl[0]));
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (3000) @(posedge pclk);
    fail_count++;
    give_verdict;
  end

  initial begin
    foreach (rx[i]) begin
      st[i] = '0;
      rx[i] = 2'h2;
      mtx[i] = 2'h1;
      iraw[i] = 3'h2;
    end
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int p = 0; p < NUM_PORTS; p++) begin
      rdc("ctrl8", 10'h068 + 10'(p * 64), 8'h00);
      rdc("result", 10'h06c + 10'(p * 64), 8'h00);
      rdc("force", 10'h070 + 10'(p * 64), 8'h5f);
      rdc("misc", 10'h074 + 10'(p * 64), 8'h00);
    end
    chk("ind", 32'h2, 32'(ind[0]));
    chk("tx", 32'h1, 32'(txl[0]));
    // Negotiated speed differs from every forced speed written below except the 8'he0 write.
    st[0].an_speed_100 <= 1'b1;
    fc(8'h80, 1'b0, 7'h00);
    fc(8'he0, 1'b0, 7'h30);
    fc(8'h20, 1'b1, 7'h70);
    fc(8'h20, 1'b0, 7'h60);
    apb(1'b1, 10'h074, 8'h80);
    apb(1'b1, 10'h068, 8'h02);
    repeat (2) @(posedge pclk);
    chk("ind", 32'h7, 32'(ind[0]));
    chk("tx", 32'h2, 32'(txl[0]));
    apb(1'b1, 10'h074, 8'h40);
    repeat (2) @(posedge pclk);
    chk("ind", 32'h2, 32'(ind[0]));
    chk("tx", 32'h0, 32'(txl[0]));
    chk("ctl", 32'h63, 32'(ctl[0]));
    apb(1'b1, 10'h068, 8'h00);
    n_rst = 0;
    apb(1'b1, 10'h074, 8'h20);
    repeat (3) @(posedge pclk);
    rdc("misc", 10'h074, 8'h00);
    chk("restarts", 32'h1, n_rst);
    n_cts = 0;
    // The result fields keep the previous test until the next done.
    prev8 = 8'h00;
    for (int k = 0; k < 4; k++) begin
      dv = 9'h0a5 + 9'(k * 195);
      apb(1'b1, 10'h068, 8'h10);
      rdc("launch", 10'h068, prev8 | 8'h10);
      st[0].result <= {k[1], 2'(k), dv};
      st[0].test_done <= 1'b1;
      @(posedge pclk);
      st[0].test_done <= 1'b0;
      prev8 = {k[1], 2'(k), 4'h0, dv[8]};
      rdc("ctrl8", 10'h068, prev8);
      dvr[8] = rd[0];
      rdc("result", 10'h06c, dv[7:0]);
      dvr[7:0] = rd[7:0];
      chk("fault_dm", 32'(dv) * 32'h4, 32'(dvr) * DIST_DM_PER_COUNT);
    end
    chk("launches", 32'h4, n_cts);
    apb(1'b1, 10'h128, 8'hff);
    rdc("absent", 10'h128, 8'h00);
    apb(1'b1, 10'h0b0, 8'h80);
    rdc("force2", 10'h0b0, 8'h9f);
    repeat (2) @(posedge pclk);
    chk("ctl2", 32'h00, 32'(ctl[1]));
    chk("ctl", 32'h60, 32'(ctl[0]));
    give_verdict;
  end
endmodule // tb_port_phy_control_regs
